// *** core/swl_map.svh ***
// Timing constants and command codes for the single-wire slave link
`ifndef SWL_MAP_SVH
`define SWL_MAP_SVH
`define SWL_CLK_MHZ 10
`define SWL_WRITE_SAMPLE_US 30
`define SWL_READ_RELEASE_US 25
`define SWL_RESET_LOW_US 480
`define SWL_PRESENCE_WAIT_US 30
`define SWL_PRESENCE_LOW_US 120
`define SWL_ERASE_BASE_US 60
`define SWL_ERASE_PER_BYTE_US 30
`define SWL_ERASE_MAX_US 1500
`define SWL_WAKE_US 100
`define SWL_CAL_HOUR_CYCLES 36'h8_61C4_6800
`define SWL_CMD_SLEEP 8'h0_0B
`define SWL_CMD_REGRESET 8'h0_0C
`define SWL_CMD_ERASE 8'h0_0E
`define SWL_CMD_PROGRAM 8'h0_0F
`define SWL_CMD_READ 8'h0_0A
`endif

// *** core/swl_pkg.sv ***
// Types for the single-wire slave link
package swl_pkg;
  typedef enum logic [2:0] {
    SWL_IDLE = 3'b000,
    SWL_LOW = 3'b001,
    SWL_PWAIT = 3'b010,
    SWL_PLOW = 3'b011,
    SWL_RDRV = 3'b100,
    SWL_WAITHI = 3'b101
  } swl_state_t;
  typedef enum logic [1:0] {
    SWL_P_CMD = 2'b00,
    SWL_P_ARG = 2'b01,
    SWL_P_DATA = 2'b10,
    SWL_P_READ = 2'b11
  } swl_phase_t;
endpackage : swl_pkg

// *** core/swl_slave.sv ***
// Device side of the single-wire open-drain link
`timescale 1ns/1ps
`include "swl_map.svh"
module swl_slave
  import swl_pkg::*;
#(
  parameter longint CAL_PERIOD = `SWL_CAL_HOUR_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Single-wire pin, open drain
  input wire logic single_wire_io_in,
  output logic single_wire_io_out,
  output logic single_wire_io_oe_b,
  // Data to send on read slots
  input wire logic [7:0] read_data,
  // Decoded traffic and calibration strobe
  output logic [7:0] cmd_byte,
  output logic [7:0] arg_byte,
  output logic cmd_valid,
  output logic reg_reset,
  output logic sleep_active,
  output logic erase_busy,
  output logic cal_strobe,
  output logic [7:0] write_data,
  output logic write_valid
);
  localparam logic [15:0] SAMPLE_CYC =
    16'(`SWL_WRITE_SAMPLE_US * `SWL_CLK_MHZ);
  localparam logic [15:0] RREL_CYC = 16'(`SWL_READ_RELEASE_US * `SWL_CLK_MHZ);
  localparam logic [15:0] RST_CYC = 16'(`SWL_RESET_LOW_US * `SWL_CLK_MHZ);
  localparam logic [15:0] PWAIT_CYC =
    16'(`SWL_PRESENCE_WAIT_US * `SWL_CLK_MHZ);
  localparam logic [15:0] PLOW_CYC = 16'(`SWL_PRESENCE_LOW_US * `SWL_CLK_MHZ);
  localparam logic [15:0] WAKE_CYC = 16'(`SWL_WAKE_US * `SWL_CLK_MHZ);
  localparam logic [15:0] ERASE_MAX_CYC =
    16'(`SWL_ERASE_MAX_US * `SWL_CLK_MHZ);

  // Erase time in cycles for a byte count, clipped to the ceiling
  function automatic logic [15:0] erase_cycles(input logic [7:0] n);
    logic [31:0] t;
    t = 32'((`SWL_ERASE_BASE_US + `SWL_ERASE_PER_BYTE_US * 32'(n))
      * `SWL_CLK_MHZ);
    erase_cycles = (t > 32'(ERASE_MAX_CYC)) ? ERASE_MAX_CYC : t[15:0];
  endfunction : erase_cycles

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  logic sync1, line, line_d;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 1'b1;
      line <= 1'b1;
      line_d <= 1'b1;
    end else begin
      sync1 <= single_wire_io_in;
      line <= sync1;
      line_d <= line;
    end
  end
  logic fall;
  assign fall = line_d & ~line;

  // ----------------------------------------------------------------
  // Slot engine
  // ----------------------------------------------------------------
  swl_state_t state, next_state;
  swl_phase_t phase, next_phase;
  logic [15:0] cnt, next_cnt, wake_cnt, next_wake_cnt;
  logic [15:0] erase_cnt, next_erase_cnt;
  logic [2:0] bitn, next_bitn;
  logic [7:0] shreg, next_shreg, txreg, next_txreg;
  logic [7:0] next_cmd_byte, next_arg_byte, next_write_data;
  logic drive, next_drive, sampled, next_sampled;
  logic next_cmd_valid, next_reg_reset, next_sleep;
  logic next_write_valid, next_erase_busy;

  always_comb begin
    next_state = state;
    next_phase = phase;
    next_cnt = (cnt == 16'hFFFF) ? cnt : cnt + 16'h0001;
    next_bitn = bitn;
    next_shreg = shreg;
    next_txreg = txreg;
    next_drive = drive;
    next_sampled = sampled;
    next_cmd_byte = cmd_byte;
    next_arg_byte = arg_byte;
    next_cmd_valid = 1'b0;
    next_reg_reset = 1'b0;
    next_sleep = sleep_active;
    next_write_valid = 1'b0;
    next_write_data = write_data;
    next_wake_cnt = wake_cnt;
    next_erase_cnt = erase_cnt;
    next_erase_busy = erase_busy;
    if (erase_busy) begin
      next_erase_cnt = erase_cnt - 16'h0001;
      if (erase_cnt <= 16'h0001) begin
        next_erase_busy = 1'b0;
      end
    end
    // Wake on any edge; the slot that woke us is dropped while waking
    if (sleep_active) begin
      next_state = SWL_IDLE;
      next_drive = 1'b0;
      if (line != line_d) begin
        next_wake_cnt = WAKE_CYC;
      end else if (wake_cnt != 16'h0000) begin
        next_wake_cnt = wake_cnt - 16'h0001;
        if (wake_cnt == 16'h0001) begin
          next_sleep = 1'b0;
        end
      end
    end else begin
      case (state)
        SWL_IDLE: begin
          if (fall) begin
            next_cnt = 16'h0000;
            next_sampled = 1'b0;
            if (phase == SWL_P_READ) begin
              next_drive = ~txreg[0];
              next_state = SWL_RDRV;
            end else begin
              next_state = SWL_LOW;
            end
          end
        end
        SWL_LOW: begin
          if (!sampled && cnt == SAMPLE_CYC) begin
            next_sampled = 1'b1;
            next_shreg = {line, shreg[7:1]};
            next_bitn = bitn + 3'd1;
            if (bitn == 3'd7) begin
              case (phase)
                SWL_P_CMD: begin
                  next_cmd_byte = {line, shreg[7:1]};
                  next_phase = SWL_P_ARG;
                end
                SWL_P_ARG: begin
                  next_arg_byte = {line, shreg[7:1]};
                  next_cmd_valid = 1'b1;
                  next_phase = SWL_P_DATA;
                  if (cmd_byte == `SWL_CMD_SLEEP) begin
                    next_sleep = 1'b1;
                    next_phase = SWL_P_CMD;
                  end else if (cmd_byte == `SWL_CMD_REGRESET) begin
                    next_reg_reset = 1'b1;
                    next_phase = SWL_P_CMD;
                  end else if (cmd_byte == `SWL_CMD_ERASE) begin
                    next_erase_busy = 1'b1;
                    next_erase_cnt = erase_cycles({line, shreg[7:1]});
                    next_phase = SWL_P_CMD;
                  end else if (cmd_byte == `SWL_CMD_READ) begin
                    next_txreg = read_data;
                    next_phase = SWL_P_READ;
                  end
                end
                default: begin
                  next_write_data = {line, shreg[7:1]};
                  next_write_valid = 1'b1;
                end
              endcase
            end
          end
          // Stay past the sample point: a one pulse ends long before it
          if (line && sampled) begin
            next_state = SWL_IDLE;
          end else if (!line && cnt >= RST_CYC) begin
            next_state = SWL_WAITHI;
          end
        end
        SWL_RDRV: begin
          if (cnt >= RREL_CYC) begin
            next_drive = 1'b0;
            // Bit already sent; the low state must not sample it again
            next_sampled = 1'b1;
            next_txreg = {1'b0, txreg[7:1]};
            next_bitn = bitn + 3'd1;
            if (bitn == 3'd7) begin
              next_txreg = read_data;
            end
            next_state = line ? SWL_IDLE : SWL_LOW;
          end
        end
        SWL_WAITHI: begin
          if (line) begin
            next_cnt = 16'h0000;
            next_state = SWL_PWAIT;
          end
        end
        SWL_PWAIT: begin
          if (cnt >= PWAIT_CYC) begin
            next_cnt = 16'h0000;
            next_drive = 1'b1;
            next_state = SWL_PLOW;
          end
        end
        SWL_PLOW: begin
          if (cnt >= PLOW_CYC) begin
            next_drive = 1'b0;
            next_bitn = 3'd0;
            next_phase = SWL_P_CMD;
            next_state = SWL_IDLE;
          end
        end
        default: begin
          next_state = SWL_IDLE;
          next_drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SWL_IDLE;
      phase <= SWL_P_CMD;
      cnt <= 16'h0000;
      bitn <= 3'd0;
      {shreg, txreg, cmd_byte, arg_byte, write_data} <= '0;
      {drive, sampled, cmd_valid, reg_reset} <= 4'h0;
      {sleep_active, write_valid, erase_busy} <= 3'h0;
      wake_cnt <= 16'h0000;
      erase_cnt <= 16'h0000;
    end else begin
      state <= next_state;
      phase <= next_phase;
      cnt <= next_cnt;
      bitn <= next_bitn;
      {shreg, txreg} <= {next_shreg, next_txreg};
      {cmd_byte, arg_byte} <= {next_cmd_byte, next_arg_byte};
      write_data <= next_write_data;
      {drive, sampled} <= {next_drive, next_sampled};
      {cmd_valid, reg_reset} <= {next_cmd_valid, next_reg_reset};
      {sleep_active, write_valid} <= {next_sleep, next_write_valid};
      erase_busy <= next_erase_busy;
      wake_cnt <= next_wake_cnt;
      erase_cnt <= next_erase_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and hourly calibration
  // ----------------------------------------------------------------
  assign single_wire_io_out = 1'b0;
  logic oe_b;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_b <= 1'b1;
    end else begin
      oe_b <= ~next_drive;
    end
  end
  assign single_wire_io_oe_b = oe_b;

  // Long count kept in its own wide counter; strobe tells the converter
  logic [35:0] cal_cnt, next_cal_cnt;
  logic next_cal;
  always_comb begin
    next_cal = 1'b0;
    next_cal_cnt = cal_cnt + 36'h1;
    if (cal_cnt >= 36'(CAL_PERIOD - 1)) begin
      next_cal_cnt = 36'h0;
      next_cal = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_cnt <= 36'h0;
      cal_strobe <= 1'b0;
    end else begin
      cal_cnt <= next_cal_cnt;
      cal_strobe <= next_cal;
    end
  end
endmodule : swl_slave

// *** testbench/swl_slave_props.sv ***
// Assertions on the single-wire slave ports
`timescale 1ns/1ps
module swl_slave_props #(
  parameter longint CAL_PERIOD = 1000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pin and status
  input wire logic single_wire_io_in,
  input wire logic single_wire_io_out,
  input wire logic single_wire_io_oe_b,
  input wire logic cmd_valid,
  input wire logic write_valid,
  input wire logic sleep_active,
  input wire logic erase_busy,
  input wire logic cal_strobe
);
  wire lin = single_wire_io_in;
  wire oe_b = single_wire_io_oe_b;
  logic [15:0] low_cnt, fall_cnt, rel_cnt, oe_cnt, ers_cnt;
  logic [63:0] cal_cnt;
  logic prev_in, prev_oe, in_pres, cal_seen, rel;
  // A rise after a long low marks the end of a link reset
  assign rel = !prev_in && lin && (low_cnt >= 16'h12C0);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {low_cnt, fall_cnt, rel_cnt, oe_cnt, ers_cnt, cal_cnt} <= '0;
      {prev_in, prev_oe, in_pres, cal_seen} <= 4'b1100;
    end else begin
      prev_in <= lin;
      prev_oe <= oe_b;
      low_cnt <= lin ? 16'h0000 : low_cnt + 16'h0001;
      fall_cnt <= (prev_in && !lin) ? 16'h0000 : fall_cnt + 16'h0001;
      rel_cnt <= rel ? 16'h0000 : rel_cnt + 16'h0001;
      oe_cnt <= oe_b ? 16'h0000 : oe_cnt + 16'h0001;
      ers_cnt <= erase_busy ? ers_cnt + 16'h0001 : 16'h0000;
      cal_cnt <= cal_strobe ? 64'h0 : cal_cnt + 64'h1;
      cal_seen <= cal_seen || cal_strobe;
      in_pres <= rel || (in_pres && !(oe_b && !prev_oe));
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_pres_start;
    in_pres && $fell(oe_b);
  endsequence
  sequence s_rd_start;
    !in_pres && $fell(oe_b);
  endsequence
  a_pres_wait: assert property (
    s_pres_start |-> rel_cnt >= 16'h0096 && rel_cnt <= 16'h0258)
    else $error("presence start out of window");
  a_pres_len: assert property (
    in_pres && $rose(oe_b) |-> oe_cnt >= 16'h0258 && oe_cnt <= 16'h0960)
    else $error("presence length out of range");
  a_read_drive: assert property (
    s_rd_start |-> (fall_cnt <= 16'h0064) ##1 !oe_b [*8])
    else $error("read zero driven late or briefly");
  a_read_valid: assert property (
    !in_pres && $rose(oe_b) |-> fall_cnt >= 16'h0096)
    else $error("read zero dropped before host sample");
  a_read_rel: assert property (
    !oe_b && !in_pres |-> fall_cnt <= 16'h012C)
    else $error("read zero held too long");
  a_pin_low: assert property (
    single_wire_io_out == 1'b0)
    else $error("pin output not low");
  a_cal_gap: assert property (
    cal_strobe && cal_seen |-> cal_cnt == CAL_PERIOD - 1)
    else $error("calibration spacing wrong");
  a_cal_pulse: assert property (
    cal_strobe |=> !cal_strobe [*8])
    else $error("calibration strobe too long");
  a_erase_max: assert property (
    erase_busy |-> ers_cnt < 16'h3A98)
    else $error("erase too long");
  a_valid_pulse: assert property (
    cmd_valid || write_valid |=> !cmd_valid && !write_valid)
    else $error("valid not a single pulse");
  a_sleep_quiet: assert property (
    sleep_active && $past(sleep_active) |-> oe_b)
    else $error("line driven while asleep");
endmodule : swl_slave_props

// *** testbench/swl_host_model.sv ***
// Host partner model driving the single-wire line
`timescale 1ns/1ps
module swl_host_model (
  // Clock
  input wire logic clk,
  // Line level and pull request
  input wire logic line_in,
  output logic host_pull
);
  // Host only pulls low; the pull-up restores the line on release
  initial host_pull = 1'b0;
  task automatic hold(input int lo, input int hi);
    host_pull = 1'b1;
    repeat (lo) @(negedge clk);
    host_pull = 1'b0;
    repeat (hi) @(negedge clk);
  endtask : hold
  task automatic reset_pulse(output logic pm, output logic pe);
    hold(4900, 650);
    pm = line_in;
    repeat (2400) @(negedge clk);
    pe = line_in;
  endtask : reset_pulse
  // Slots of 62 us keep 2 us of recovery
  task automatic write_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      if (b[i]) hold(20, 600);
      else hold(600, 20);
    end
  endtask : write_byte
  task automatic read_byte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      hold(20, 110);
      v[i] = line_in;
      repeat (490) @(negedge clk);
    end
  endtask : read_byte
endmodule : swl_host_model

// *** testbench/testbench.sv ***
// Self-checking bench for the single-wire slave
`timescale 1ns/1ps
`include "swl_map.svh"
`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); \
  end \
end
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] read_data = 8'h00;
  logic host_pull, dev_out, dev_oe_b, cmd_valid, reg_reset, sleep_active;
  logic erase_busy, cal_strobe, write_valid;
  logic [7:0] cmd_byte, arg_byte, write_data;
  logic [15:0] exp_q[$];
  logic [15:0] exp_v;
  int fails = 0;
  int n_tests = 0;
  int n_rr = 0;
  int cyc = 0;
  int seed = 10621;
  wire line_lvl = !host_pull && dev_oe_b;
  swl_slave #(.CAL_PERIOD(1000)) i_swl_slave (
    .clk(clk), .rst_b(rst_b), .single_wire_io_in(line_lvl),
    .single_wire_io_out(dev_out), .single_wire_io_oe_b(dev_oe_b),
    .read_data(read_data), .cmd_byte(cmd_byte), .arg_byte(arg_byte),
    .cmd_valid(cmd_valid), .reg_reset(reg_reset),
    .sleep_active(sleep_active), .erase_busy(erase_busy),
    .cal_strobe(cal_strobe), .write_data(write_data),
    .write_valid(write_valid)
  );
  swl_host_model i_swl_host_model (
    .clk(clk), .line_in(line_lvl), .host_pull(host_pull)
  );
  initial forever #50 clk = ~clk;
  always @(negedge clk) begin
    if (reg_reset) n_rr++;
    if (cmd_valid || write_valid) exp_v = exp_q.pop_front();
    if (cmd_valid) `CHK("command", exp_v, {cmd_byte, arg_byte})
    if (write_valid) `CHK("data", exp_v, {8'h00, write_data})
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic send(input logic [7:0] c, input logic [7:0] a);
    exp_q.push_back({c, a});
    i_swl_host_model.write_byte(c);
    i_swl_host_model.write_byte(a);
  endtask : send
  task automatic do_reset;
    logic pm, pe;
    i_swl_host_model.reset_pulse(pm, pe);
    `CHK("presence", 1'b0, pm)
    `CHK("released", 1'b1, pe)
  endtask : do_reset
  initial begin
    logic [7:0] v, rd, n, c;
    int cnt;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    do_reset();
    send(`SWL_CMD_REGRESET, 8'h00);
    `CHK("reg_reset", 1, n_rr)
    n = 8'($random(seed)) & 8'h0F;
    send(`SWL_CMD_ERASE, n);
    `CHK("erase_busy", 1'b1, erase_busy)
    cnt = 0;
    while (erase_busy && cnt < 20000) begin
      @(negedge clk);
      cnt++;
    end
    `CHK("erase_time", 1'b1, cnt <= (60 + 30 * n) * 10)
    $display("test reset and erase done");
    rd = 8'($random(seed));
    read_data = rd;
    send(`SWL_CMD_READ, 8'h00);
    i_swl_host_model.read_byte(v);
    `CHK("read_byte", rd, v)
    $display("test read done");
    do_reset();
    c = 8'h40 | (8'($random(seed)) & 8'h0F);
    v = 8'($random(seed));
    send(c, 8'($random(seed)));
    exp_q.push_back({8'h00, v});
    i_swl_host_model.write_byte(v);
    $display("test write done");
    do_reset();
    send(`SWL_CMD_SLEEP, 8'h00);
    `CHK("sleep_active", 1'b1, sleep_active)
    i_swl_host_model.write_byte(8'h00);
    `CHK("pending", 0, exp_q.size())
    repeat (1100) @(negedge clk);
    `CHK("awake", 1'b0, sleep_active)
    $display("test sleep done");
    wrap_up();
  end
endmodule : testbench
bind swl_slave swl_slave_props #(.CAL_PERIOD(CAL_PERIOD)) i_swl_slave_props (
  .clk(clk), .rst_b(rst_b), .single_wire_io_in(single_wire_io_in),
  .single_wire_io_out(single_wire_io_out),
  .single_wire_io_oe_b(single_wire_io_oe_b), .cmd_valid(cmd_valid),
  .write_valid(write_valid), .sleep_active(sleep_active),
  .erase_busy(erase_busy), .cal_strobe(cal_strobe)
);
